/* File: src/bstpre_pkg.sv */
// Package: command codes, field positions and burst constants for the
// burst-stop / precharge sequencer. Shared by the sequencer and its
// link-side command decoder.
package bstpre_pkg;
   // Command field positions on the rising-edge command/address word
   localparam int CA_W          = 10;
   localparam int CA_SEL0       = 0;
   localparam int CA_SEL1       = 1;
   localparam int CA_SEL2       = 2;
   localparam int CA_SEL3       = 3;
   localparam int CA_ALL_BANKS  = 4;
   localparam int CA_BANK_LO    = 7;
   localparam int CA_BANK_HI    = 9;
   localparam int BANK_W        = 3;
   localparam int NUM_BANKS     = 8;
   // Burst length codes
   localparam logic [1:0] BL_4  = 2'h0;
   localparam logic [1:0] BL_8  = 2'h1;
   localparam logic [1:0] BL_16 = 2'h2;
   localparam int BEAT_CNT_W    = 5;
   localparam int CLK_CNT_W     = 4;
   // Decoded command kinds
   typedef enum logic [2:0] {
      CMD_NONE, CMD_READ, CMD_WRITE, CMD_STOP, CMD_PRE
   } cmd_kind_t;
   localparam logic [7:0] BANKS_NONE = 8'h00;
   localparam logic [7:0] BANKS_ALL  = 8'hFF;
endpackage

/* File: src/bstpre_link_if.sv */
// Interface: decoded command word passed from the link-side decoder to
// the sequencer. Both ends sit on the link clock.
`timescale 1ns/100ps
interface bstpre_link_if;
   import bstpre_pkg::*;
   cmd_kind_t          kind;
   logic               all_banks_flag;
   logic [BANK_W-1:0]  bank;
   logic               auto_pre;
   modport dec (output kind, output all_banks_flag, output bank, output auto_pre);
   modport seq (input kind, input all_banks_flag, input bank, input auto_pre);
endinterface

/* File: src/bstpre_cmd_decode.sv */
// Command decoder: registers one command per rising link clock edge.
// Assumes chip select and CA arrive synchronous to the link clock.
`timescale 1ns/100ps
module bstpre_cmd_decode
   import bstpre_pkg::*;
(
   // Link side
   input  wire logic            i_clk_link,
   input  wire logic            i_rst_link,
   input  wire logic            i_cs_n,
   input  wire logic [CA_W-1:0] i_ca,
   input  wire logic            i_ap,
   // Decoded command
   bstpre_link_if.dec           dec
);
   cmd_kind_t         kind_d,  kind_q;
   logic              ab_d,    ab_q;
   logic [BANK_W-1:0] bank_d,  bank_q;
   logic              ap_d,    ap_q;

   // Command truth table
   always_comb begin
      kind_d = CMD_NONE;
      ab_d   = i_ca[CA_ALL_BANKS];
      bank_d = i_ca[CA_BANK_HI:CA_BANK_LO];
      ap_d   = i_ap;
      if (!i_cs_n && i_ca[CA_SEL0]) begin
         if (!i_ca[CA_SEL1]) begin
            kind_d = i_ca[CA_SEL2] ? CMD_READ : CMD_WRITE;
         end else if (!i_ca[CA_SEL2]) begin
            kind_d = i_ca[CA_SEL3] ? CMD_PRE : CMD_STOP;
         end
      end
   end

   always_ff @(posedge i_clk_link) begin
      if (i_rst_link) begin
         kind_q <= CMD_NONE;
         ab_q   <= 1'b0;
         bank_q <= '0;
         ap_q   <= 1'b0;
      end else begin
         kind_q <= kind_d;
         ab_q   <= ab_d;
         bank_q <= bank_d;
         ap_q   <= ap_d;
      end
   end

   assign dec.kind           = kind_q;
   assign dec.all_banks_flag = ab_q;
   assign dec.bank           = bank_q;
   assign dec.auto_pre       = ap_q;
endmodule

/* File: src/burst_stop_precharge_seq.sv */
// Sequencer: tracks the newest burst, truncates it on burst stop or
// interrupting write, gates write beats with the byte mask, and closes
// banks on precharge. Link logic on i_clk_link; status shown on i_clk_sys.
// Assumes the controller keeps its own spacing rules.
`timescale 1ns/100ps
// Summary of operation
// - interrupted write length is twice clock gap
// - stop decoded CS low, CA 1100
// - stopped length twice clocks to stop
// - stop affects only newest burst
// - read data ends latency after stop
// - write sampling ends latency after stop
// - byte mask suppresses storing that byte
// - precharge decoded CS low, CA 1101
// - all-banks flag or bank bits select
module burst_stop_precharge_seq
   import bstpre_pkg::*;
#(
   parameter int BYTES      = 4,
   parameter int READ_LAT   = 3,
   parameter int WRITE_LAT  = 1,
   parameter bit EIGHT_BANK = 1'b1
)(
   // System clock domain
   input  wire logic             i_clk_sys,
   input  wire logic             i_srst,
   // Link clock domain pins
   input  wire logic             i_clk_link,
   input  wire logic             i_rst_link,
   input  wire logic             i_cs_n,
   input  wire logic [CA_W-1:0]  i_ca,
   input  wire logic             i_ap,
   input  wire logic [BYTES-1:0] i_write_byte_mask,
   // Configuration
   input  wire logic [1:0]       i_burst_len,
   input  wire logic [7:0]       i_bank_open,
   // Link-side outputs
   output logic                  o_rd_data_en,
   output logic                  o_wr_sample_en,
   output logic [BYTES-1:0]      o_wr_byte_en,
   // System-side status
   output logic [7:0]            o_banks_closed,
   output logic [BEAT_CNT_W-1:0] o_eff_len
);
   localparam int LAT_W = 8;

   bstpre_link_if lnk ();

   bstpre_cmd_decode u_dec (
      .i_clk_link (i_clk_link),
      .i_rst_link (i_rst_link),
      .i_cs_n     (i_cs_n),
      .i_ca       (i_ca),
      .i_ap       (i_ap),
      .dec        (lnk.dec)
   );

   // Burst tracking state (link domain)
   logic [CLK_CNT_W-1:0]  clk_left_d,  clk_left_q;   // clocks of newest burst left
   logic [CLK_CNT_W-1:0]  since_d,     since_q;      // clocks since newest read or write
   logic                  is_wr_d,     is_wr_q;
   logic                  stop_ok_d,   stop_ok_q;
   logic [BEAT_CNT_W-1:0] eff_d,       eff_q;
   logic [7:0]            closed_d,    closed_q;
   logic                  flip_d,      flip_q;
   logic [LAT_W-1:0]      rd_pipe_d,   rd_pipe_q;
   logic [LAT_W-1:0]      wr_pipe_d,   wr_pipe_q;
   logic                  rd_en_d,     rd_en_q;
   logic                  wr_en_d,     wr_en_q;
   logic [BYTES-1:0]      be_d,        be_q;
   logic [BYTES-1:0]      mask_s1_q;                // mask beat, aligned to enable pipe
   logic [7:0]            open_s1_q,   open_s2_q;   // bank-open level synchroniser
   logic [CLK_CNT_W-1:0]  half_bl;
   logic                  burst_live;

   always_comb begin
      case (i_burst_len)
         BL_8:    half_bl = CLK_CNT_W'(4);
         BL_16:   half_bl = CLK_CNT_W'(8);
         default: half_bl = CLK_CNT_W'(2);
      endcase
   end
   assign burst_live = (clk_left_q != '0);

   // Command handling and burst length bookkeeping
   always_comb begin
      clk_left_d = burst_live ? clk_left_q - CLK_CNT_W'(1) : clk_left_q;
      since_d    = (since_q == '1) ? since_q : since_q + CLK_CNT_W'(1);
      is_wr_d    = is_wr_q;
      stop_ok_d  = stop_ok_q;
      eff_d      = eff_q;
      closed_d   = closed_q & ~open_s2_q;
      flip_d     = flip_q;
      case (lnk.kind)
         CMD_READ, CMD_WRITE: begin
            // Newest command supersedes the running one
            if (burst_live && is_wr_q && lnk.kind == CMD_WRITE) begin
               eff_d  = {since_q, 1'b0};
               flip_d = ~flip_q;
            end
            clk_left_d = half_bl;  // Count includes this edge's beat
            since_d    = CLK_CNT_W'(1);
            is_wr_d    = (lnk.kind == CMD_WRITE);
            stop_ok_d  = 1'b1;
         end
         CMD_STOP: begin
            if (burst_live && stop_ok_q) begin
               eff_d      = {since_q, 1'b0};
               clk_left_d = '0;
               stop_ok_d  = 1'b0;
               flip_d     = ~flip_q;
            end
         end
         CMD_PRE: begin
            // Set wins over a same-cycle open, other clears are kept
            if (lnk.all_banks_flag) begin
               closed_d = BANKS_ALL;
            end else if (EIGHT_BANK) begin
               closed_d = closed_d | (8'h01 << lnk.bank);
            end else begin
               closed_d = closed_d | (8'h01 << lnk.bank[1:0]);
            end
         end
         default: ;
      endcase
   end

   // Data enables delayed by latency; stop truncates after latency
   always_comb begin
      rd_pipe_d = {rd_pipe_q[LAT_W-2:0], burst_live_next(1'b0)};
      wr_pipe_d = {wr_pipe_q[LAT_W-2:0], burst_live_next(1'b1)};
      rd_en_d   = rd_pipe_q[READ_LAT-1];
      wr_en_d   = wr_pipe_q[WRITE_LAT-1];
      be_d      = wr_pipe_q[WRITE_LAT-1] ? ~mask_s1_q : '0;
   end

   function automatic logic burst_live_next(input logic wr);
      burst_live_next = (clk_left_d != '0 || lnk.kind == CMD_READ
                         || lnk.kind == CMD_WRITE) && (is_wr_d == wr);
   endfunction

   always_ff @(posedge i_clk_link) begin
      if (i_rst_link) begin
         clk_left_q <= '0;
         since_q    <= '0;
         is_wr_q    <= 1'b0;
         stop_ok_q  <= 1'b0;
         eff_q      <= '0;
         closed_q   <= BANKS_NONE;
         flip_q     <= 1'b0;
         rd_pipe_q  <= '0;
         wr_pipe_q  <= '0;
         rd_en_q    <= 1'b0;
         wr_en_q    <= 1'b0;
         be_q       <= '0;
         mask_s1_q  <= '0;
         open_s1_q  <= '0;
         open_s2_q  <= '0;
      end else begin
         clk_left_q <= clk_left_d;
         since_q    <= since_d;
         is_wr_q    <= is_wr_d;
         stop_ok_q  <= stop_ok_d;
         eff_q      <= eff_d;
         closed_q   <= closed_d;
         flip_q     <= flip_d;
         rd_pipe_q  <= rd_pipe_d;
         wr_pipe_q  <= wr_pipe_d;
         rd_en_q    <= rd_en_d;
         wr_en_q    <= wr_en_d;
         be_q       <= be_d;
         mask_s1_q  <= i_write_byte_mask;  // Mask pins sampled like data
         open_s1_q  <= i_bank_open;  // Open levels come from another clock
         open_s2_q  <= open_s1_q;
      end
   end

   assign o_rd_data_en   = rd_en_q;
   assign o_wr_sample_en = wr_en_q;
   assign o_wr_byte_en   = be_q;

   // Crossing to system clock: toggle sync for length, levels for banks
   logic             tg_s1_q, tg_s2_q, tg_s3_q;
   logic [7:0]       cl_s1_q, cl_s2_q;
   logic [7:0]       banks_d, banks_q;
   logic [BEAT_CNT_W-1:0] len_d, len_q;

   always_comb begin
      banks_d = cl_s2_q;
      len_d   = (tg_s2_q != tg_s3_q) ? eff_q : len_q;  // eff_q stable since toggle
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         tg_s1_q <= 1'b0;
         tg_s2_q <= 1'b0;
         tg_s3_q <= 1'b0;
         cl_s1_q <= BANKS_NONE;
         cl_s2_q <= BANKS_NONE;
         banks_q <= BANKS_NONE;
         len_q   <= '0;
      end else begin
         tg_s1_q <= flip_q;
         tg_s2_q <= tg_s1_q;
         tg_s3_q <= tg_s2_q;
         cl_s1_q <= closed_q;
         cl_s2_q <= cl_s1_q;
         banks_q <= banks_d;
         len_q   <= len_d;
      end
   end

   assign o_banks_closed = banks_q;
   assign o_eff_len      = len_q;
endmodule

/* File: sim/bstpre_sva.sv */
// Checker: enable timing, truncation and bank status at the top ports.
// Bound from the bench; link checks on i_clk_link, status on i_clk_sys.
`timescale 1ns/100ps
module bstpre_sva
   import bstpre_pkg::*;
#(
   parameter int BYTES     = 4,
   parameter int READ_LAT  = 3,
   parameter int WRITE_LAT = 1
)(
   // Clocks and resets
   input wire logic             i_clk_sys,
   input wire logic             i_srst,
   input wire logic             i_clk_link,
   input wire logic             i_rst_link,
   // Watched pins
   input wire logic             i_cs_n,
   input wire logic [CA_W-1:0]  i_ca,
   input wire logic [BYTES-1:0] i_write_byte_mask,
   input wire logic [1:0]       i_burst_len,
   input wire logic [7:0]       i_bank_open,
   input wire logic             o_rd_data_en,
   input wire logic             o_wr_sample_en,
   input wire logic [BYTES-1:0] o_wr_byte_en,
   input wire logic [7:0]       o_banks_closed
);
   localparam int WD  = WRITE_LAT + 2;
   localparam int RD  = READ_LAT + 2;
   localparam int WD1 = WD - 1;
   localparam int RD1 = RD - 1;
   logic       wr, rd, stp, pre;
   logic [7:0] seen_q;
   logic [7:0] open_cnt_q;
   // Command decode of the link word
   assign wr  = !i_cs_n && i_ca[2:0] == 3'h1;
   assign rd  = !i_cs_n && i_ca[2:0] == 3'h5;
   assign stp = !i_cs_n && i_ca[3:0] == 4'h3;
   assign pre = !i_cs_n && i_ca[3:0] == 4'hB;
   // Banks that have seen any precharge
   always_ff @(posedge i_clk_link)
      if (i_rst_link) seen_q <= 8'h00;
      else if (pre) seen_q <= i_ca[4] ? 8'hFF : seen_q | (8'h01 << i_ca[9:7]);
   // System cycles with every bank reported open, saturating
   always_ff @(posedge i_clk_sys)
      if (i_srst || i_bank_open != 8'hFF) open_cnt_q <= 8'h00;
      else if (open_cnt_q != 8'hFF) open_cnt_q <= open_cnt_q + 8'h01;
   a_wr_start:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      wr |-> ##WD o_wr_sample_en) else $error("write sampling late");
   a_rd_start:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      rd |-> ##RD o_rd_data_en) else $error("read data late");
   a_stop_wr_end:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      wr ##2 stp |-> ##WD1 o_wr_sample_en ##1 !o_wr_sample_en)
      else $error("stopped write ends wrong");
   a_stop_rd_end:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      rd ##4 stp |-> ##RD1 o_rd_data_en ##1 !o_rd_data_en)
      else $error("stopped read ends wrong");
   a_wr_length:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      (wr && i_burst_len == BL_8) ##1 i_cs_n [*7] |-> !o_wr_sample_en
      && $past(o_wr_sample_en) && $past(o_wr_sample_en, 4))
      else $error("write burst length wrong");
   a_rd_length:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      (rd && i_burst_len == BL_16) ##1 i_cs_n [*8] |-> ##4 o_rd_data_en ##1 !o_rd_data_en)
      else $error("read burst length wrong");
   a_byte_mask:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      o_wr_sample_en |-> o_wr_byte_en == ~$past(i_write_byte_mask, 2))
      else $error("byte enable not from mask");
   a_closed_cause:
   assert property (@(posedge i_clk_sys) disable iff (i_srst)
      (o_banks_closed & ~seen_q) == 8'h00) else $error("bank closed without precharge");
   a_open_clears:
   assert property (@(posedge i_clk_sys) disable iff (i_srst)
      open_cnt_q == 8'h18 |-> o_banks_closed == 8'h00)
      else $error("open bank still closed");
   a_byte_idle:
   assert property (@(posedge i_clk_link) disable iff (i_rst_link)
      !o_wr_sample_en |-> o_wr_byte_en == '0)
      else $error("byte enable outside write");
endmodule

/* File: sim/bstpre_ctl_model.sv */
// Controller model: one command per call on the link clock, byte mask
// walking every cycle. Spacing is set by the caller through idle.
`timescale 1ns/100ps
module bstpre_ctl_model
   import bstpre_pkg::*;
(
   // Link clock
   input  wire logic       i_clk_link,
   // Command and mask pins
   output logic            o_cs_n,
   output logic [CA_W-1:0] o_ca,
   output logic            o_ap,
   output logic [3:0]      o_mask
);
   initial begin
      o_cs_n = 1'b1;
      o_ca = 10'h000;
      o_ap = 1'b0;
      o_mask = 4'h0;
   end
   // Mask pattern changes each beat so stale masks show up
   always @(posedge i_clk_link) o_mask <= {o_mask[2:0], ~o_mask[3]};
   // Command word, selected for exactly one edge
   task automatic cmd(input cmd_kind_t k, input logic [2:0] bk, input logic ab);
      @(posedge i_clk_link);
      o_cs_n <= 1'b0;
      o_ap <= ab && k == CMD_WRITE;
      case (k)
         CMD_READ:  o_ca <= 10'h005;
         CMD_WRITE: o_ca <= 10'h001;
         CMD_STOP:  o_ca <= 10'h003;
         default:   o_ca <= {bk, 2'h0, ab, 4'hB};
      endcase
   endtask
   // Deselected cycles; CA inverts so old words never look held
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge i_clk_link);
         o_cs_n <= 1'b1;
         o_ca <= ~o_ca;
      end
   endtask
endmodule

/* File: sim/tb_top.sv */
// Bench: command sequences through the controller model, checking beat
// counts, truncated length and closed banks. Both clocks made here.
`timescale 1ns/100ps
module tb_top;
   import bstpre_pkg::*;
   logic                  i_clk_sys, i_srst, i_clk_link, i_rst_link, i_cs_n, i_ap;
   logic [CA_W-1:0]       i_ca;
   logic [3:0]            i_write_byte_mask, o_wr_byte_en;
   logic [1:0]            i_burst_len;
   logic [7:0]            i_bank_open, o_banks_closed;
   logic                  o_rd_data_en, o_wr_sample_en;
   logic [BEAT_CNT_W-1:0] o_eff_len;
   int                    err_total, checked, wr_cnt, rd_cnt;
   burst_stop_precharge_seq dut_u (.i_clk_sys, .i_srst, .i_clk_link, .i_rst_link,
      .i_cs_n, .i_ca, .i_ap, .i_write_byte_mask, .i_burst_len, .i_bank_open,
      .o_rd_data_en, .o_wr_sample_en, .o_wr_byte_en, .o_banks_closed, .o_eff_len);
   bstpre_ctl_model ctl_u (.i_clk_link, .o_cs_n(i_cs_n), .o_ca(i_ca), .o_ap(i_ap),
      .o_mask(i_write_byte_mask));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      i_clk_link = 1'b0;
      #7;
      forever #24 i_clk_link = ~i_clk_link;
   end
   // Beat counters on the link clock
   always @(posedge i_clk_link) begin
      wr_cnt = wr_cnt + int'(o_wr_sample_en === 1'b1);
      rd_cnt = rd_cnt + int'(o_rd_data_en === 1'b1);
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic go(input cmd_kind_t k, input int gap);
      ctl_u.cmd(k, 3'h0, 1'b0);
      ctl_u.idle(gap - 1);
   endtask
   task automatic fin(input string nm, input int ew, input int er, input int el);
      ctl_u.idle(14);
      chk({nm, " write beats"}, 8'(ew), 8'(wr_cnt));
      chk({nm, " read beats"}, 8'(er), 8'(rd_cnt));
      chk({nm, " length"}, 8'(el), {3'h0, o_eff_len});
      $display("test %s done", nm);
      wr_cnt = 0;
      rd_cnt = 0;
   endtask
   task automatic pre(input logic [2:0] bk, input logic ab, input logic [7:0] e);
      ctl_u.cmd(CMD_PRE, bk, ab);
      ctl_u.idle(8);
      chk("closed banks", e, o_banks_closed);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog well past the expected run
   initial begin
      #60us;
      err_total++;
      test_done;
   end
   initial begin
      {i_srst, i_rst_link, i_burst_len, i_bank_open} = {2'h3, BL_8, 8'h00};
      {err_total, checked, wr_cnt, rd_cnt} = '0;
      repeat (16) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      @(posedge i_clk_link);
      i_rst_link <= 1'b0;
      ctl_u.idle(2);
      ctl_u.cmd(CMD_WRITE, 3'h0, 1'b1);
      fin("full write", 4, 0, 0);
      go(CMD_WRITE, 2);
      go(CMD_STOP, 1);
      fin("stopped write", 2, 0, 4);
      i_burst_len <= BL_16;
      go(CMD_WRITE, 6);
      go(CMD_WRITE, 1);
      fin("interrupted write", 14, 0, 12);
      go(CMD_READ, 4);
      go(CMD_STOP, 1);
      fin("stopped read", 0, 4, 8);
      go(CMD_WRITE, 4);
      go(CMD_WRITE, 2);
      go(CMD_STOP, 2);
      go(CMD_STOP, 1);
      fin("newest stopped", 6, 0, 4);
      go(CMD_READ, 1);
      fin("full read", 0, 8, 4);
      i_burst_len <= BL_4;
      go(CMD_WRITE, 2);
      go(CMD_WRITE, 2);
      fin("seamless short write", 4, 0, 4);
      pre(3'h5, 1'b0, 8'h20);
      pre(3'h2, 1'b0, 8'h24);
      pre(3'h0, 1'b1, 8'hFF);
      @(posedge i_clk_sys) i_bank_open <= 8'hFF;
      repeat (30) @(posedge i_clk_sys);
      chk("reopened", 8'h00, o_banks_closed);
      i_bank_open <= 8'h00;
      $display("test precharge done");
      test_done;
   end
endmodule
bind burst_stop_precharge_seq bstpre_sva #(.BYTES(BYTES), .READ_LAT(READ_LAT),
   .WRITE_LAT(WRITE_LAT)) chk_u (.i_clk_sys, .i_srst, .i_clk_link, .i_rst_link,
   .i_cs_n, .i_ca, .i_write_byte_mask, .i_burst_len, .i_bank_open, .o_rd_data_en,
   .o_wr_sample_en, .o_wr_byte_en, .o_banks_closed);
